// ### hdl/rsq_top.sv
// Reset sequencer with cause flags, register reset values and APB access.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Contract
// [R1] Four sources start the reset sequence.
// [R2] Detection sets latch, clears both counters.
// [R3] Delay timer counts after source pulse ends.
// [R4] Start-up counter runs after delay timeout.
// [R5] Start-up done clears latch, ends reset.
// [R6] Reset lasts selected delay plus 16 cycles.
// [R7] Unchanged bits survive pin and watchdog resets.
// [R8] Port E direction loads per package variant.
// [R9] Power resets set both flags; pin keeps.
// [R10] Pin reset in sleep: timeout 1, powerdown 0.
// [R11] Watchdog reset running: timeout 0, powerdown 1; code leaves powerdown unchanged.
// [R12] Watchdog wake from sleep: both flags 0.
// [R13] Clear-watchdog sets both; timeout clears timeout.
// [R14] Registers load values by reset type.
// [R15] Two-bit select picks 18/4.5/288/72 ms.
// [R16] Start-up counter counts 16 oscillator cycles.
// [R17] Reset held while delay timer runs.
// [R18] Sleep clears powerdown, sets timeout.
module rsq_top
    import rsq_pkg::*;
#(
    parameter int DLY_18_CYC = RSQ_DLY_18_CYC,
    parameter int DLY_4P5_CYC = RSQ_DLY_4P5_CYC,
    parameter int DLY_288_CYC = RSQ_DLY_288_CYC,
    parameter int DLY_72_CYC = RSQ_DLY_72_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_on_reset,
    input wire logic brown_out_reset,
    input wire logic external_reset_pin_n,
    input wire logic osc_in,
    input wire logic package_type_a,
    input wire logic watchdog_timeout,
    input wire logic sleep_instruction,
    input wire logic clear_watchdog_instruction,
    input wire logic wake_change,
    output logic chip_reset,
    output logic timeout_flag,
    output logic power_down_flag,
    output logic [7:0] port_e_direction,
    output logic irq
);
    logic [4:0] pin_sync;
    rsq_src_t src;
    logic src_any;
    rsq_src_t src_d_reg;
    logic osc_d_reg;
    logic osc_rise;
    rsq_state_t state_reg;
    logic [RSQ_DLY_W-1:0] power_up_delay_timer;
    logic [RSQ_DLY_W-1:0] delay_lim;
    logic [RSQ_START_W-1:0] osc_startup_counter;
    logic asleep_reg;
    logic core_run;
    logic sleep_ok;
    logic clear_wdg_ok;
    logic [2:0] status_hi_reg;
    logic [2:0] status_lo_reg;
    logic [7:0] core_status_flags;
    logic [1:0] reset_delay_select;
    logic [RSQ_IRQ_W-1:0] irq_stat_reg;
    logic [RSQ_IRQ_W-1:0] irq_mask_reg;
    logic [RSQ_IRQ_W-1:0] irq_ev;
    logic wr_en;
    logic setup;
    logic [31:0] rdata_next;
    logic hit;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Pins from outside the clock domain pass two flops first.
    rsq_sync #(
        .W(5)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d({power_on_reset, brown_out_reset, ~external_reset_pin_n, osc_in,
            package_type_a}),
        .q(pin_sync)
    );

    // Source levels; the watchdog pulse is already on this clock.
    assign src.por = pin_sync[4];
    assign src.brown = pin_sync[3];
    assign src.pin = pin_sync[2];
    assign src.wdt = watchdog_timeout;
    assign src_any = |src; // see [R1]
    assign osc_rise = pin_sync[1] && !osc_d_reg;

    // Edge history for event detection on sources and the oscillator.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_d_reg <= '0;
            osc_d_reg <= 1'b0;
        end else begin
            src_d_reg <= src;
            osc_d_reg <= pin_sync[1];
        end
    end

    // Delay limit follows the two-bit select.
    always_comb begin
        unique case (reset_delay_select) // see [R15]
            RSQ_DSEL_18: delay_lim = RSQ_DLY_W'(DLY_18_CYC);
            RSQ_DSEL_4P5: delay_lim = RSQ_DLY_W'(DLY_4P5_CYC);
            RSQ_DSEL_288: delay_lim = RSQ_DLY_W'(DLY_288_CYC);
            RSQ_DSEL_72: delay_lim = RSQ_DLY_W'(DLY_72_CYC);
        endcase
    end

    // Sequencer: a new source always returns to hold, from any state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= RSQ_HOLD;
        end else if (src_any) begin
            state_reg <= RSQ_HOLD; // see [R1] see [R2]
        end else begin
            unique case (state_reg)
                RSQ_HOLD: state_reg <= RSQ_DELAY; // see [R3]
                RSQ_DELAY: begin
                    if (power_up_delay_timer == delay_lim - 1'b1) begin
                        state_reg <= RSQ_START; // see [R4]
                    end
                end
                RSQ_START: begin
                    if (osc_rise &&
                        osc_startup_counter == RSQ_START_W'(RSQ_START_CYC - 1)) begin
                        state_reg <= RSQ_RUN; // see [R5] see [R6]
                    end
                end
                RSQ_RUN: state_reg <= RSQ_RUN;
                default: state_reg <= RSQ_HOLD;
            endcase
        end
    end

    // Delay timer runs only in its state and is zero elsewhere except in the first start-up cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_up_delay_timer <= '0;
        end else if (state_reg == RSQ_DELAY && !src_any) begin
            power_up_delay_timer <= power_up_delay_timer + 1'b1;
        end else begin
            power_up_delay_timer <= '0; // see [R2]
        end
    end

    // Start-up counter counts oscillator rising edges, not clock cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_startup_counter <= '0;
        end else if (state_reg != RSQ_START || src_any) begin
            osc_startup_counter <= '0; // see [R2]
        end else if (osc_rise) begin
            osc_startup_counter <= osc_startup_counter + 1'b1; // see [R16]
        end
    end

    // The latch is every state except run.
    assign chip_reset = (state_reg != RSQ_RUN); // see [R17] see [R5]
    assign core_run = (state_reg == RSQ_RUN) && !src_any;
    assign sleep_ok = core_run && sleep_instruction;
    assign clear_wdg_ok = core_run && clear_watchdog_instruction;

    // Sleep lasts until a wake change or any reset source.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            asleep_reg <= 1'b0;
        end else if (src_any || wake_change) begin
            asleep_reg <= 1'b0;
        end else if (sleep_ok) begin
            asleep_reg <= 1'b1;
        end
    end

    // Cause flags. Power loss wins, then the watchdog, then instructions.
    // A pin reset writes nothing, so in sleep the 1/0 left by sleep stands.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag <= 1'b1;
            power_down_flag <= 1'b1;
        end else if (src.por || src.brown) begin
            timeout_flag <= 1'b1; // see [R9]
            power_down_flag <= 1'b1;
        end else if (src.wdt) begin
            timeout_flag <= 1'b0; // see [R11] see [R12] see [R13]
        end else if (src.pin) begin
            timeout_flag <= timeout_flag; // see [R9] see [R10]
        end else if (sleep_ok) begin
            timeout_flag <= 1'b1; // see [R18]
            power_down_flag <= 1'b0;
        end else if (clear_wdg_ok) begin
            timeout_flag <= 1'b1; // see [R13]
            power_down_flag <= 1'b1;
        end
    end

    // APB decode; the slave never waits, so pready is constant high.
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign core_status_flags = {status_hi_reg, timeout_flag, power_down_flag,
                                status_lo_reg};

    // Status: upper bits clear on any reset, lower bits only on the bus reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_hi_reg <= RSQ_ST_HI_RST;
            status_lo_reg <= RSQ_ST_LO_RST;
        end else if (src_any) begin
            status_hi_reg <= RSQ_ST_HI_RST; // see [R14] see [R7]
        end else if (wr_en && paddr == RSQ_A_STATUS) begin
            status_hi_reg <= pwdata[7:5];
            status_lo_reg <= pwdata[2:0];
        end
    end

    // Port E direction reloads from the variant strap while the chip is held in reset,
    // so a smaller variant gets its own value after a bus reset as well.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_e_direction <= RSQ_PORTE_A_RST;
        end else if (src_any || chip_reset) begin
            port_e_direction <= pin_sync[0] ? RSQ_PORTE_A_RST
                                            : RSQ_PORTE_B_RST; // see [R8]
        end else if (wr_en && paddr == RSQ_A_PORTE) begin
            port_e_direction <= pwdata[7:0];
        end
    end

    // Delay select survives chip resets; only the bus reset restores it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_delay_select <= RSQ_DSEL_18;
        end else if (wr_en && paddr == RSQ_A_CFG) begin
            reset_delay_select <= pwdata[1:0];
        end
    end

    // Interrupt events are source onsets and the release of reset.
    assign irq_ev[RSQ_IRQ_POWER] = (src.por && !src_d_reg.por) ||
                                   (src.brown && !src_d_reg.brown);
    assign irq_ev[RSQ_IRQ_PIN] = src.pin && !src_d_reg.pin;
    assign irq_ev[RSQ_IRQ_WDT] = src.wdt && !src_d_reg.wdt;
    assign irq_ev[RSQ_IRQ_DONE] = (state_reg == RSQ_START) && !src_any && osc_rise &&
        osc_startup_counter == RSQ_START_W'(RSQ_START_CYC - 1);

    // Sticky status, write one to clear; a new event beats the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= '0;
        end else if (wr_en && paddr == RSQ_A_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[RSQ_IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_ev;
        end
    end

    // Mask register, same layout as status.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= '0;
        end else if (wr_en && paddr == RSQ_A_IRQ_MASK) begin
            irq_mask_reg <= pwdata[RSQ_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

    // Read mux; an unmapped address reads zero and flags an error.
    always_comb begin
        rdata_next = 32'h0;
        hit = 1'b1;
        unique case (paddr)
            RSQ_A_STATUS: rdata_next[7:0] = core_status_flags;
            RSQ_A_PORTE: rdata_next[7:0] = port_e_direction;
            RSQ_A_CFG: rdata_next[1:0] = reset_delay_select;
            RSQ_A_IRQ_STAT: rdata_next[RSQ_IRQ_W-1:0] = irq_stat_reg;
            RSQ_A_IRQ_MASK: rdata_next[RSQ_IRQ_W-1:0] = irq_mask_reg;
            RSQ_A_SEQ: rdata_next[5:0] = {asleep_reg, chip_reset, state_reg};
            default: hit = 1'b0;
        endcase
    end

    // Read data and error are captured in setup and held through access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0 : rdata_next;
            pslverr <= !hit;
        end
    end

    // Checks on the sequence and the flags.
    a_src_to_hold: assert property (src_any |=> state_reg == RSQ_HOLD) // see [R1]
        else $error("reset source did not set the latch");
    a_hold_counters: assert property (state_reg == RSQ_HOLD |-> // see [R2]
        power_up_delay_timer == '0 && osc_startup_counter == '0)
        else $error("counters not cleared in hold");
    a_delay_waits: assert property ((state_reg == RSQ_HOLD && src_any) |=> // see [R3]
        state_reg != RSQ_DELAY)
        else $error("delay timer started while source active");
    a_start_after_delay: assert property ($rose(state_reg == RSQ_START) |-> // see [R4]
        $past(state_reg) == RSQ_DELAY &&
        $past(power_up_delay_timer) == delay_lim - 1'b1)
        else $error("start-up counter began before delay timeout");
    a_release_start: assert property ($fell(chip_reset) |-> // see [R5]
        $past(state_reg) == RSQ_START &&
        $past(osc_startup_counter) == RSQ_START_W'(RSQ_START_CYC - 1))
        else $error("reset released without full start-up count");
    // The timer is its own register, so this does not hold merely by construction.
    a_reset_held: assert property (power_up_delay_timer != '0 |-> chip_reset) // see [R17]
        else $error("reset not held during delay");
    a_porte_load: assert property ((src_any && !pin_sync[0]) |=> // see [R8]
        port_e_direction == RSQ_PORTE_B_RST)
        else $error("port e direction wrong after reset");
    a_power_flags: assert property ((src.por || src.brown) |=> // see [R9]
        timeout_flag && power_down_flag)
        else $error("power reset did not set both flags");
    a_wdt_flags: assert property ((src.wdt && !src.por && !src.brown) |=> // see [R11]
        !timeout_flag && power_down_flag == $past(power_down_flag))
        else $error("watchdog flags wrong");
    a_pin_keep: assert property ((src.pin && !src.wdt && !src.por && !src.brown) |=> // see [R10]
        $stable(timeout_flag) && $stable(power_down_flag))
        else $error("pin reset changed flags");
    a_sleep_flags: assert property (sleep_ok |=> timeout_flag && !power_down_flag) // see [R18]
        else $error("sleep flags wrong");
    a_stat_hi_clr: assert property (src_any |=> status_hi_reg == RSQ_ST_HI_RST) // see [R14]
        else $error("status upper bits not reset");

    c_release: cover property ($fell(chip_reset));
    c_wdt_sleep: cover property (asleep_reg && src.wdt);
    c_pin_sleep: cover property (asleep_reg && src.pin);
    c_irq: cover property ($rose(irq));
endmodule : rsq_top

// ### hdl/rsq_pkg.sv
// Shared constants, types and the register map of the reset sequencer.
package rsq_pkg;
    // Clock rate in MHz and the four power-up delays in microseconds.
    localparam int RSQ_CLK_MHZ = 20;
    localparam int RSQ_DLY_18_US = 18000;
    localparam int RSQ_DLY_4P5_US = 4500;
    localparam int RSQ_DLY_288_US = 288000;
    localparam int RSQ_DLY_72_US = 72000;
    localparam int RSQ_DLY_18_CYC = RSQ_DLY_18_US * RSQ_CLK_MHZ;
    localparam int RSQ_DLY_4P5_CYC = RSQ_DLY_4P5_US * RSQ_CLK_MHZ;
    localparam int RSQ_DLY_288_CYC = RSQ_DLY_288_US * RSQ_CLK_MHZ;
    localparam int RSQ_DLY_72_CYC = RSQ_DLY_72_US * RSQ_CLK_MHZ;
    localparam int RSQ_DLY_W = 23;
    localparam int RSQ_START_CYC = 16;
    localparam int RSQ_START_W = 5;
    // Register indices; the byte address is four times the index.
    localparam int RSQ_IDX_STATUS = 8'h03;
    localparam int RSQ_IDX_PORTE = 8'h09;
    localparam int RSQ_IDX_CFG = 8'h10;
    localparam int RSQ_IDX_IRQ_STAT = 8'h11;
    localparam int RSQ_IDX_IRQ_MASK = 8'h12;
    localparam int RSQ_IDX_SEQ = 8'h13;
    localparam logic [11:0] RSQ_A_STATUS = 12'(RSQ_IDX_STATUS * 4);
    localparam logic [11:0] RSQ_A_PORTE = 12'(RSQ_IDX_PORTE * 4);
    localparam logic [11:0] RSQ_A_CFG = 12'(RSQ_IDX_CFG * 4);
    localparam logic [11:0] RSQ_A_IRQ_STAT = 12'(RSQ_IDX_IRQ_STAT * 4);
    localparam logic [11:0] RSQ_A_IRQ_MASK = 12'(RSQ_IDX_IRQ_MASK * 4);
    localparam logic [11:0] RSQ_A_SEQ = 12'(RSQ_IDX_SEQ * 4);
    // Status field positions and reset values.
    localparam int RSQ_ST_TMO = 4;
    localparam int RSQ_ST_PDN = 3;
    localparam logic [2:0] RSQ_ST_HI_RST = 3'h0;
    localparam logic [2:0] RSQ_ST_LO_RST = 3'h0;
    localparam logic [7:0] RSQ_PORTE_A_RST = 8'hff;
    localparam logic [7:0] RSQ_PORTE_B_RST = 8'h3f;
    // Delay select codes; the 18 ms code is the reset value.
    localparam logic [1:0] RSQ_DSEL_18 = 2'h3;
    localparam logic [1:0] RSQ_DSEL_4P5 = 2'h2;
    localparam logic [1:0] RSQ_DSEL_288 = 2'h1;
    localparam logic [1:0] RSQ_DSEL_72 = 2'h0;
    // Interrupt status bits.
    localparam int RSQ_IRQ_W = 4;
    localparam int RSQ_IRQ_POWER = 0;
    localparam int RSQ_IRQ_PIN = 1;
    localparam int RSQ_IRQ_WDT = 2;
    localparam int RSQ_IRQ_DONE = 3;

    typedef struct packed {
        logic por;
        logic brown;
        logic pin;
        logic wdt;
    } rsq_src_t;

    typedef enum logic [3:0] {
        RSQ_HOLD = 4'b0001,
        RSQ_DELAY = 4'b0010,
        RSQ_START = 4'b0100,
        RSQ_RUN = 4'b1000
    } rsq_state_t;
endpackage : rsq_pkg

// ### hdl/rsq_sync.sv
// Two-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module rsq_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule : rsq_sync

// ### testbench/tb_top.sv
// Self-checking testbench for the reset sequencer with cause flags.
`timescale 1ns/1ps
module tb_top;
    import rsq_pkg::*;
    // Shortened power-up delays keep the run brief; every expected reset length derives from them.
    localparam int N18 = 20;
    localparam int N4P5 = 10;
    localparam int N288 = 40;
    localparam int N72 = 30;
    localparam int LIMIT = 20000;
    typedef struct {
        logic [1:0] sel;
        int n;
        int src;
        int hold;
        logic [1:0] flags;
        logic [31:0] stat;
    } rsq_row_t;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic power_on_reset, brown_out_reset, external_reset_pin_n, osc_in, package_type_a;
    logic watchdog_timeout, sleep_instruction, clear_watchdog_instruction, wake_change;
    logic chip_reset, timeout_flag, power_down_flag, irq, er;
    logic [7:0] port_e_direction;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    int dur;
    rsq_row_t rows [4];

    rsq_top #(.DLY_18_CYC(N18), .DLY_4P5_CYC(N4P5), .DLY_288_CYC(N288),
        .DLY_72_CYC(N72)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_on_reset(power_on_reset), .brown_out_reset(brown_out_reset),
        .external_reset_pin_n(external_reset_pin_n), .osc_in(osc_in),
        .package_type_a(package_type_a), .watchdog_timeout(watchdog_timeout),
        .sleep_instruction(sleep_instruction),
        .clear_watchdog_instruction(clear_watchdog_instruction),
        .wake_change(wake_change), .chip_reset(chip_reset), .timeout_flag(timeout_flag),
        .power_down_flag(power_down_flag), .port_e_direction(port_e_direction), .irq(irq));

    // Bus clock; the oscillator input runs free at half the bus rate.
    always #25 pclk = ~pclk;
    always @(posedge pclk) osc_in <= ~osc_in;

    // A hang is cut short here and counted as a mismatch.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Checks: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; a clock passes first so no signal is driven twice in one step.
    // The wait on pready has no count of its own: only the bench timeout ends a hang.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rdat, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rd, er);
    endtask : wr_reg

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
    endtask : rd_chk

    // Source codes: 0 power-on, 1 brown-out, 2 pin, 3 watchdog.
    task automatic set_src(input int src, input logic v);
        case (src)
            0: power_on_reset <= v;
            1: brown_out_reset <= v;
            2: external_reset_pin_n <= ~v;
            default: watchdog_timeout <= v;
        endcase
    endtask : set_src

    task automatic wait_run(output int d);
        d = 0;
        while (chip_reset !== 1'b0) begin
            @(posedge pclk);
            d++;
        end
    endtask : wait_run

    // Holds a source for some edges, then counts edges until the chip leaves reset.
    task automatic fire(input int src, input int hold, output int d);
        @(posedge pclk);
        set_src(src, 1'b1);
        repeat (hold) @(posedge pclk);
        set_src(src, 1'b0);
        @(posedge pclk);
        wait_run(d);
        d++;
    endtask : fire

    // Pins pass a two-flop synchroniser, so they arrive two edges after the watchdog.
    task automatic chk_len(input int d, input int n, input int src);
        int e;
        e = n + 32 + ((src == 3) ? 1 : 3);
        chk({31'h0, (d >= e - 3) && (d <= e + 5)}, 32'h1);
    endtask : chk_len

    // Codes: 0 sleep, 1 clear watchdog, 2 wake change.
    task automatic pulse(input int which);
        @(posedge pclk);
        sleep_instruction <= (which == 0);
        clear_watchdog_instruction <= (which == 1);
        wake_change <= (which == 2);
        @(posedge pclk);
        {sleep_instruction, clear_watchdog_instruction, wake_change} <= '0;
        @(posedge pclk);
    endtask : pulse

    // Main sequence: table of reset kinds, then hand-written awkward cases.
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {power_on_reset, brown_out_reset, watchdog_timeout, osc_in} = '0;
        {sleep_instruction, clear_watchdog_instruction, wake_change} = '0;
        external_reset_pin_n = 1'b1;
        package_type_a = 1'b1;
        rows[0] = '{RSQ_DSEL_18, N18, 0, 4, 2'b11, 32'h9};
        rows[1] = '{RSQ_DSEL_4P5, N4P5, 3, 1, 2'b01, 32'hc};
        rows[2] = '{RSQ_DSEL_288, N288, 2, 50, 2'b01, 32'ha};
        rows[3] = '{RSQ_DSEL_72, N72, 1, 4, 2'b11, 32'h9};
        repeat (8) @(posedge pclk);
        chk({31'h0, chip_reset}, 32'h1);
        chk({24'h0, port_e_direction}, 32'hff);
        chk({30'h0, timeout_flag, power_down_flag}, 32'h3);
        presetn <= 1'b1;
        wait_run(dur);
        chk({31'h0, dur > N18}, 32'h1);
        rd_chk(RSQ_A_STATUS, 32'h18);
        rd_chk(RSQ_A_CFG, 32'h3);
        rd_chk(RSQ_A_PORTE, 32'hff);
        rd_chk(RSQ_A_IRQ_MASK, 32'h0);
        foreach (rows[i]) begin
            wr_reg(RSQ_A_CFG, {30'h0, rows[i].sel});
            wr_reg(RSQ_A_IRQ_STAT, 32'hf);
            fire(rows[i].src, rows[i].hold, dur);
            chk_len(dur, rows[i].n, rows[i].src);
            chk({30'h0, timeout_flag, power_down_flag}, {30'h0, rows[i].flags});
            rd_chk(RSQ_A_IRQ_STAT, rows[i].stat);
        end
        // A second pin reset during the delay restarts the delay timer.
        @(posedge pclk);
        set_src(2, 1'b1);
        repeat (4) @(posedge pclk);
        set_src(2, 1'b0);
        repeat (20) @(posedge pclk);
        fire(2, 4, dur);
        chk_len(dur, N72, 2);
        // Sleep, wake without reset, then pin and watchdog resets taken from sleep.
        pulse(0);
        chk({30'h0, timeout_flag, power_down_flag}, 32'h2);
        rd_chk(RSQ_A_SEQ, 32'h28);
        pulse(2);
        rd_chk(RSQ_A_SEQ, 32'h08);
        pulse(0);
        fire(2, 4, dur);
        chk({30'h0, timeout_flag, power_down_flag}, 32'h2);
        pulse(1);
        chk({30'h0, timeout_flag, power_down_flag}, 32'h3);
        pulse(0);
        fire(3, 1, dur);
        chk({30'h0, timeout_flag, power_down_flag}, 32'h0);
        // Status retention, port E reload and interrupt masking across a pin reset.
        wr_reg(RSQ_A_STATUS, 32'hff);
        rd_chk(RSQ_A_STATUS, 32'he7);
        wr_reg(RSQ_A_PORTE, 32'h12);
        rd_chk(RSQ_A_PORTE, 32'h12);
        wr_reg(RSQ_A_IRQ_STAT, 32'hf);
        fire(2, 4, dur);
        chk({30'h0, timeout_flag, power_down_flag}, 32'h0);
        rd_chk(RSQ_A_STATUS, 32'h07);
        chk({24'h0, port_e_direction}, 32'hff);
        chk({31'h0, irq}, 32'h0);
        wr_reg(RSQ_A_IRQ_MASK, 32'h2);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr_reg(RSQ_A_IRQ_STAT, 32'h2);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd_chk(RSQ_A_IRQ_STAT, 32'h8);
        // The smaller package variant reloads port E direction on a watchdog reset.
        package_type_a <= 1'b0;
        repeat (4) @(posedge pclk);
        fire(3, 1, dur);
        chk({24'h0, port_e_direction}, 32'h3f);
        rd_chk(RSQ_A_PORTE, 32'h3f);
        // An unmapped word is refused for read and write alike, with no wait state.
        apb(1'b0, 12'h3fc, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h3fc, 32'h5a, rd, er);
        chk({31'h0, er}, 32'h1);
        chk({31'h0, pready}, 32'h1);
        complete_run();
    end
endmodule : tb_top
